//--- accel_target.sv
// Purpose: Sensor power-up sequencing, mode control and serial target
// Assumes: reset_n is the power-on reset pulse; sample_in is a converter word
// Notes:   Bus pins and the address pin are synchronised before use
`timescale 1ns/1ps
// Function
// [R1] Address 001001 plus select pin bit
// [R2] Works at 100 kHz and 400 kHz
// [R3] Target only, never starts a transfer
// [R4] Power-on reset loads register defaults
// [R5] After power-on reset, wait in standby
// [R6] Power-on copies image values, enters standby
// [R7] Bus ready within 250 us of power
// [R8] Conversion ready 2 ms after power
// [R9] No sample within 1 ms wakeup
// [R10] Sample rate four times bandwidth when high-rate
// [R11] Samples carry 10-bit resolution
// [R12] All logic runs on internal clock
// [R13] Writing b6 to 36 resets registers
// [R14] Register 11 bit 7 selects active
// [R15] Image reload takes about 100 us
// [R16] No address acknowledge before power-up ends
// [R17] Address pin sampled once, then held
module accel_target #(
  parameter int POR_CYCLES     = accel_link_pkg::POR_CYC,
  parameter int STARTUP_CYCLES = accel_link_pkg::STARTUP_CYC,
  parameter int WAKE_CYCLES    = accel_link_pkg::WAKE_CYC,
  parameter int RELOAD_CYCLES  = accel_link_pkg::RELOAD_CYC,
  parameter int ODR_BASE_CYCLES = accel_link_pkg::ODR_BASE_CYC,
  parameter logic [7:0] NVM_TRIM = 8'h00
)(
  input  wire logic       clock,
  input  wire logic       reset_n,
  i2c_link_if.target      bus,
  input  wire logic       address_select_pin,
  input  wire logic [9:0] sample_in,
  output logic            mode_active,
  output logic            conv_ready,
  output logic            sample_strobe,
  output logic            reload_busy
);
  import accel_link_pkg::*;

  if (POR_CYCLES < 1 || STARTUP_CYCLES < 1 || WAKE_CYCLES < 1 ||
      RELOAD_CYCLES < 1 || ODR_BASE_CYCLES < 1 ||
      ODR_BASE_CYCLES > 8_000_000) begin : g_chk
    $error("accel_target timing parameter out of range");
  end

  typedef enum logic [1:0] {
    P_POR    = 2'b00,
    P_STBY   = 2'b01,
    P_ACTIVE = 2'b10,
    P_RELOAD = 2'b11
  } pwr_t;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_ADDR  = 3'b001,
    T_REG   = 3'b010,
    T_WDATA = 3'b011,
    T_RDATA = 3'b100
  } tstate_t;

  pwr_t        pwr_r;
  tstate_t     ts_r;
  logic [31:0] timer_r;
  logic [31:0] start_cnt_r;
  logic [31:0] wake_cnt_r;
  logic [31:0] odr_cnt_r;
  logic [31:0] odr_lim;
  logic [3:0]  odr_sh;
  logic [7:0]  mode_r;
  logic [7:0]  bw_r;
  logic [7:0]  trim_r;
  logic        load_r;
  logic        addr_lsb_r;
  logic [9:0]  data_r;
  logic        conv_ready_r;
  logic        strobe_r;
  logic        active_r;
  logic        busy_r;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        mack_r;
  logic        sda_oe_r;
  logic        wr_r;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_data_r;
  logic [7:0]  rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; logic reads the second stage and its delayed copy, never the first

  always_ff @(posedge clock) begin // R12
    if (!reset_n) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= {address_select_pin, bus.scl, bus.sda};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[1];
      sda_d_r <= sync2_r[0];
    end
  end

  assign scl_s    = sync2_r[1];
  assign sda_s    = sync2_r[0];
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Power sequence and control registers

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pwr_r      <= P_POR; // R4
      timer_r    <= 32'h0;
      mode_r     <= MODE_DEF;
      bw_r       <= BW_DEF;
      trim_r     <= 8'h00;
      load_r     <= 1'b0;
      addr_lsb_r <= 1'b0;
    end else begin
      unique case (pwr_r)
        P_POR: begin
          timer_r <= timer_r + 32'h1;
          if (timer_r == 32'(POR_CYCLES - 1)) begin // R7
            trim_r     <= NVM_TRIM; // R6
            addr_lsb_r <= sync2_r[2]; // R17
            timer_r    <= 32'h0;
            pwr_r      <= P_STBY; // R5
          end
        end
        P_STBY: if (mode_r[MODE_BIT]) pwr_r <= P_ACTIVE; // R14
        P_ACTIVE: begin
          if (!mode_r[MODE_BIT]) begin
            pwr_r <= P_STBY; // R14
          end else if (load_r) begin
            // A reload asked for in standby waits for active mode
            pwr_r   <= P_RELOAD;
            timer_r <= 32'h0;
          end
        end
        P_RELOAD: begin
          timer_r <= timer_r + 32'h1;
          if (timer_r == 32'(RELOAD_CYCLES - 1)) begin // R15
            trim_r           <= NVM_TRIM;
            load_r           <= 1'b0;
            mode_r[MODE_BIT] <= 1'b0;
            pwr_r            <= P_STBY;
          end
        end
      endcase
      // Register writes come last so a write wins over a hardware clear
      if (wr_r) begin
        unique case (wr_addr_r)
          REG_MODE: mode_r <= wr_data_r;
          REG_BW:   bw_r   <= wr_data_r;
          REG_TRIM: trim_r <= wr_data_r;
          REG_NVM:  if (wr_data_r[LOAD_BIT]) load_r <= 1'b1;
          REG_SRST: if (wr_data_r == SRST_VAL) begin // R13
            mode_r  <= MODE_DEF;
            bw_r    <= BW_DEF;
            trim_r  <= NVM_TRIM;
            load_r  <= 1'b0;
            timer_r <= 32'h0;
            pwr_r   <= P_STBY;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Startup and wakeup gating of conversions

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      start_cnt_r  <= 32'h0;
      wake_cnt_r   <= 32'h0;
      conv_ready_r <= 1'b0;
      active_r     <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      if (start_cnt_r != 32'(STARTUP_CYCLES)) begin
        start_cnt_r <= start_cnt_r + 32'h1; // R8
      end
      if (pwr_r != P_ACTIVE) begin
        wake_cnt_r <= 32'h0; // R9
      end else if (wake_cnt_r != 32'(WAKE_CYCLES)) begin
        wake_cnt_r <= wake_cnt_r + 32'h1;
      end
      conv_ready_r <= (pwr_r == P_ACTIVE) && mode_r[MODE_BIT] &&
                      (start_cnt_r == 32'(STARTUP_CYCLES)) &&
                      (wake_cnt_r == 32'(WAKE_CYCLES)); // R8 R9
      active_r     <= (pwr_r == P_ACTIVE);
      busy_r       <= (pwr_r == P_RELOAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample timing: each halving of bandwidth doubles the period

  always_comb begin
    odr_sh = {1'b0, BW_MAX_CODE - bw_r[2:0]} + {3'h0, !bw_r[HRS_BIT]}; // R10
    odr_lim = 32'(ODR_BASE_CYCLES) << odr_sh;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      odr_cnt_r <= 32'h0;
      data_r    <= 10'h000;
      strobe_r  <= 1'b0;
    end else begin
      strobe_r <= 1'b0;
      if (!conv_ready_r) begin
        odr_cnt_r <= 32'h0;
      end else if (odr_cnt_r >= odr_lim - 32'h1) begin
        odr_cnt_r <= 32'h0;
        data_r    <= sample_in; // R11
        strobe_r  <= 1'b1;
      end else begin
        odr_cnt_r <= odr_cnt_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data for the register pointer

  always_comb begin
    unique case (ptr_r)
      REG_DATA_LO: rd_byte = {data_r[1:0], 6'h00};
      REG_DATA_HI: rd_byte = data_r[9:2];
      REG_BW:      rd_byte = bw_r;
      REG_MODE:    rd_byte = mode_r;
      REG_TRIM:    rd_byte = trim_r;
      REG_NVM:     rd_byte = {4'h0, load_r, pwr_r != P_RELOAD, 2'h0};
      default:     rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial target: sample on SCL rise, drive SDA after SCL fall

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ts_r      <= T_IDLE;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
      wr_r      <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      if (start_c) begin
        ts_r     <= T_ADDR;
        bit_r    <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_c) begin
        ts_r     <= T_IDLE;
        sda_oe_r <= 1'b0;
      end else if (ts_r != T_IDLE && scl_rise) begin // R2
        if (bit_r != BIT_ACK) begin
          sh_r <= {sh_r[6:0], sda_s};
        end else begin
          mack_r <= !sda_s;
        end
        bit_r <= bit_r + 4'h1;
      end else if (ts_r != T_IDLE && scl_fall) begin
        if (bit_r == BIT_ACK) begin
          unique case (ts_r)
            T_ADDR: begin
              if (sh_r[7:1] == {ADDR_HI, addr_lsb_r} && pwr_r != P_POR) begin // R1 R16
                sda_oe_r <= 1'b1;
                rw_r     <= sh_r[0];
              end else begin
                ts_r <= T_IDLE;
              end
            end
            T_REG: begin
              ptr_r    <= sh_r;
              sda_oe_r <= 1'b1;
            end
            T_WDATA: begin
              wr_r      <= 1'b1; // R3
              wr_addr_r <= ptr_r;
              wr_data_r <= sh_r;
              ptr_r     <= ptr_r + 8'h01;
              sda_oe_r  <= 1'b1;
            end
            default: sda_oe_r <= 1'b0;
          endcase
        end else if (bit_r == BIT_DONE) begin
          bit_r    <= 4'h0;
          sda_oe_r <= 1'b0;
          unique case (ts_r)
            T_ADDR: ts_r <= rw_r ? T_RDATA : T_REG;
            T_REG:  ts_r <= T_WDATA;
            T_RDATA: if (!mack_r) ts_r <= T_IDLE;
            default: ;
          endcase
          // Master acknowledge or a fresh read address fetches a byte
          if ((ts_r == T_ADDR && rw_r) || (ts_r == T_RDATA && mack_r)) begin
            sda_oe_r <= !rd_byte[7];
            tx_r     <= {rd_byte[6:0], 1'b0};
            ptr_r    <= ptr_r + 8'h01;
          end
        end else if (ts_r == T_RDATA) begin
          sda_oe_r <= !tx_r[7];
          tx_r     <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  assign bus.sda_t_o    = 1'b0;
  assign bus.sda_t_oe   = sda_oe_r;
  assign mode_active    = active_r;
  assign conv_ready     = conv_ready_r;
  assign sample_strobe  = strobe_r;
  assign reload_busy    = busy_r;
endmodule

//--- accel_link_pkg.sv
// Purpose: Shared constants for the sensor front end and its bus master
// Assumes: 50 MHz system clock on both ends
// Notes:   Register offsets are byte addresses on the serial link
package accel_link_pkg;
  localparam int CLK_HZ = 50_000_000;
  // Fixed upper six address bits, low bit from the select pin
  localparam logic [5:0] ADDR_HI = 6'h09;
  // Times as printed, then in clock cycles
  localparam int POR_US = 250;
  localparam int POR_CYC = POR_US * (CLK_HZ / 1_000_000);
  localparam int STARTUP_MS = 2;
  localparam int STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
  localparam int WAKE_MS = 1;
  localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
  localparam int RELOAD_US = 100;
  localparam int RELOAD_CYC = RELOAD_US * (CLK_HZ / 1_000_000);
  // Link rates; quarter bit times rounded up so the rate never exceeds them
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  localparam int STD_Q_CYC = (CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int FAST_Q_CYC = (CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  // Highest sample rate, at the widest bandwidth code with the high-rate bit set
  localparam int ODR_MAX_HZ = 2000;
  localparam int ODR_BASE_CYC = CLK_HZ / ODR_MAX_HZ;
  localparam logic [2:0] BW_MAX_CODE = 3'h7;
  // Register map
  localparam logic [7:0] REG_DATA_LO = 8'h01;
  localparam logic [7:0] REG_DATA_HI = 8'h02;
  localparam logic [7:0] REG_BW = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h11;
  localparam logic [7:0] REG_TRIM = 8'h27;
  localparam logic [7:0] REG_NVM = 8'h33;
  localparam logic [7:0] REG_SRST = 8'h36;
  localparam int MODE_BIT = 7;
  localparam int HRS_BIT = 7;
  localparam int LOAD_BIT = 3;
  localparam int RDY_BIT = 2;
  localparam logic [7:0] SRST_VAL = 8'hb6;
  localparam logic [7:0] MODE_DEF = 8'h00;
  localparam logic [7:0] BW_DEF = 8'h87;
  // Bit counter marks within a byte
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
endpackage

//--- i2c_link_if.sv
// Purpose: Open-drain serial link between target and master
// Assumes: Pull-ups on both wires, no other drivers
// Notes:   Wire levels are resolved here from the output enables
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_t_oe & ~sda_t_o));
  modport target (input scl, input sda, output sda_t_o, output sda_t_oe);
  modport master (input scl, input sda, output scl_m_o, output scl_m_oe,
                  output sda_m_o, output sda_m_oe);
endinterface

//--- accel_master.sv
// Purpose: Bus master that writes or reads one sensor register per command
// Assumes: Target never stretches the clock
// Notes:   Clock is divided from the system clock; fast_mode picks the rate
`timescale 1ns/1ps
module accel_master #(
  parameter int BOOT_CYCLES = accel_link_pkg::POR_CYC
)(
  input  wire logic       clock,
  input  wire logic       reset_n,
  i2c_link_if.master      bus,
  input  wire logic       fast_mode,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic       cmd_addr_sel,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            resp_valid,
  output logic [7:0]      resp_rdata,
  output logic            resp_nack
);
  import accel_link_pkg::*;

  if (BOOT_CYCLES < 1) begin : g_chk
    $error("BOOT_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {
    H_BOOT  = 3'b000,
    H_IDLE  = 3'b001,
    H_START = 3'b010,
    H_BYTE  = 3'b011,
    H_STOP  = 3'b100
  } hstate_t;

  hstate_t     st_r;
  logic [31:0] boot_r;
  logic [7:0]  q_r;
  logic [7:0]  q_lim;
  logic        qtick;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [1:0]  seq_r;
  logic        rd_r;
  logic        sel_r;
  logic [7:0]  reg_r;
  logic [7:0]  wdata_r;
  logic [7:0]  tx_r;
  logic [7:0]  rx_r;
  logic        nack_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic        ready_r;
  logic        rv_r;
  logic [1:0]  sync1_r;
  logic [1:0]  sync2_r;
  logic        rx_phase;

  ////////////////////////////////////////////////////////////////////////
  // Quarter-bit timebase and line sampling

  assign q_lim = fast_mode ? 8'(FAST_Q_CYC) : 8'(STD_Q_CYC); // R2
  // Compare with >= so a rate change between commands cannot leave q_r past the limit
  assign qtick = (q_r >= q_lim - 8'h01);

  always_ff @(posedge clock) begin
    if (!reset_n || qtick) begin
      q_r <= 8'h00;
    end else begin
      q_r <= q_r + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
    end else begin
      sync1_r <= {bus.scl, bus.sda};
      sync2_r <= sync1_r;
    end
  end

  function automatic logic [7:0] byte_for(input logic [1:0] s);
    if (s == 2'h0) begin
      byte_for = {ADDR_HI, sel_r, 1'b0}; // R1
    end else if (s == 2'h1) begin
      byte_for = reg_r;
    end else begin
      byte_for = rd_r ? {ADDR_HI, sel_r, 1'b1} : wdata_r;
    end
  endfunction

  // Byte 3 of a read is the data byte coming back
  assign rx_phase = (seq_r == 2'h3);

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r     <= H_BOOT;
      boot_r   <= 32'h0;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      seq_r    <= 2'h0;
      rd_r     <= 1'b0;
      sel_r    <= 1'b0;
      reg_r    <= 8'h00;
      wdata_r  <= 8'h00;
      tx_r     <= 8'h00;
      rx_r     <= 8'h00;
      nack_r   <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ready_r  <= 1'b0;
      rv_r     <= 1'b0;
      resp_rdata <= 8'h00;
      resp_nack  <= 1'b0;
    end else begin
      rv_r <= 1'b0;
      unique case (st_r)
        H_BOOT: begin
          // Target is not addressed until its power-on time has passed
          boot_r <= boot_r + 32'h1; // R7
          if (boot_r == 32'(BOOT_CYCLES - 1)) begin
            st_r    <= H_IDLE;
            ready_r <= 1'b1;
          end
        end
        H_IDLE: begin
          ph_r <= 2'h0;
          if (cmd_valid) begin
            rd_r    <= cmd_read;
            sel_r   <= cmd_addr_sel;
            reg_r   <= cmd_reg;
            wdata_r <= cmd_wdata;
            seq_r   <= 2'h0;
            nack_r  <= 1'b0;
            ready_r <= 1'b0;
            st_r    <= H_START; // R3
          end
        end
        H_START: if (qtick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: begin
              scl_oe_r <= 1'b1;
              sda_oe_r <= 1'b0;
            end
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b1;
            2'h3: begin
              scl_oe_r <= 1'b1;
              bit_r    <= 4'h0;
              tx_r     <= byte_for(seq_r);
              st_r     <= H_BYTE;
            end
          endcase
        end
        H_BYTE: if (qtick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: sda_oe_r <= (bit_r != BIT_ACK) && !rx_phase && !tx_r[7];
            2'h1: scl_oe_r <= 1'b0;
            2'h2: begin
              if (bit_r != BIT_ACK) begin
                rx_r <= {rx_r[6:0], sync2_r[0]};
                tx_r <= {tx_r[6:0], 1'b0};
              end else if (!rx_phase) begin
                nack_r <= sync2_r[0];
              end
            end
            2'h3: begin
              scl_oe_r <= 1'b1;
              bit_r    <= bit_r + 4'h1;
              if (bit_r == BIT_ACK) begin
                bit_r <= 4'h0;
                if (nack_r || rx_phase || (seq_r == 2'h2 && !rd_r)) begin
                  st_r <= H_STOP;
                end else if (seq_r == 2'h1 && rd_r) begin
                  seq_r <= 2'h2;
                  st_r  <= H_START;
                end else begin
                  seq_r <= seq_r + 2'h1;
                  tx_r  <= byte_for(seq_r + 2'h1);
                end
              end
            end
          endcase
        end else if (ph_r == 2'h0 && bit_r == BIT_ACK && q_r == 8'h00) begin
          // Let go of data one cycle after the clock falls: keeps hold time and
          // clears the wire before the target's acknowledge arrives
          sda_oe_r <= 1'b0;
        end
        H_STOP: if (qtick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            2'h3: begin
              rv_r       <= 1'b1;
              resp_rdata <= rx_r;
              resp_nack  <= nack_r;
              ready_r    <= 1'b1;
              st_r       <= H_IDLE;
            end
          endcase
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign bus.scl_m_o  = 1'b0;
  assign bus.sda_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_oe_r;
  assign bus.sda_m_oe = sda_oe_r;
  assign cmd_ready    = ready_r;
  assign resp_valid   = rv_r;
endmodule

//--- accel_link_asserts.sv
// Purpose: Wire checks on the serial link between the two ends
// Assumes: One clock for both ends; reset_n is the target's reset
// Notes:   Bit-phase limits are the 400 kHz ones, which 100 kHz also meets
`timescale 1ns/1ps
module accel_link_asserts #(
  parameter int POR_CYCLES = 2000
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_t_o,
  input wire logic sda_t_oe,
  input wire logic scl,
  input wire logic sda
);
  int por_r;
  int hi_r;
  int lo_r;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!reset_n) por_r <= 0;
    else if (por_r < POR_CYCLES) por_r <= por_r + 1;
  end
  // No reset on the phase counters, so a target reset cannot fake a short phase
  always_ff @(posedge clock) begin
    if (!scl) hi_r <= 0;
    else if (hi_r < 255) hi_r <= hi_r + 1;
  end
  always_ff @(posedge clock) begin
    if (scl) lo_r <= 0;
    else if (lo_r < 255) lo_r <= lo_r + 1;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_open_drain; !scl_m_o && !sda_m_o && !sda_t_o; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain value not low");
  property p_clock_master; scl == !scl_m_oe; endproperty
  a_clock_master: assert property (p_clock_master)
    else $error("clock wire not set by master alone");
  property p_tgt_edge; $changed(sda_t_oe) |-> !scl; endproperty
  a_tgt_edge: assert property (p_tgt_edge)
    else $error("target moved data while clock high");
  property p_no_fight; !(sda_m_oe && sda_t_oe); endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends pulling data low");
  property p_por_quiet; por_r < POR_CYCLES |-> !sda_t_oe; endproperty
  a_por_quiet: assert property (p_por_quiet)
    else $error("target drove data during power-on");
  property p_scl_high; $fell(scl) |-> hi_r >= 60; endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  property p_scl_low; $rose(scl) |-> lo_r >= 30; endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  property p_tgt_hold; $rose(sda_t_oe) |-> sda_t_oe [*8]; endproperty
  a_tgt_hold: assert property (p_tgt_hold)
    else $error("target data pulse too short");
  c_ack: cover property ($rose(sda_t_oe));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule

//--- tb.sv
// Purpose: End-to-end bench, bus master and sensor target joined by the link
// Assumes: Inputs change on the falling clock edge
// Notes:   Power-up and rate counts are shortened through parameters
`timescale 1ns/1ps
module tb;
  import accel_link_pkg::*;
  localparam int POR = 2000;
  localparam int WAKE = 100;
  localparam int BASE = 20;
  // Arbitrary image value, unlike anything the bench writes
  localparam logic [7:0] TRIM = 8'h3c;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       rst_t_n = 1'b0;
  logic       pin = 1'b0;
  logic       fast = 1'b1;
  logic       cv = 1'b0;
  logic       cr = 1'b0;
  logic       cs = 1'b0;
  logic [7:0] cg = 8'h00;
  logic [7:0] cw = 8'h00;
  logic       ry, rv, rk, mode, ss, rb, cvr;
  logic [7:0] rdat;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         wk = 0;
  int         nrb = 0;
  ////////////////////////////////////////////////////////////
  i2c_link_if i2c_link_if_i ();
  accel_master #(.BOOT_CYCLES(POR)) accel_master_i (
    .clock(clock), .reset_n(rst_n), .bus(i2c_link_if_i), .fast_mode(fast),
    .cmd_valid(cv), .cmd_read(cr), .cmd_addr_sel(cs), .cmd_reg(cg), .cmd_wdata(cw),
    .cmd_ready(ry), .resp_valid(rv), .resp_rdata(rdat), .resp_nack(rk));
  accel_target #(.POR_CYCLES(POR), .STARTUP_CYCLES(200), .WAKE_CYCLES(WAKE),
    .RELOAD_CYCLES(40), .ODR_BASE_CYCLES(BASE), .NVM_TRIM(TRIM)) accel_target_i (
    .clock(clock), .reset_n(rst_t_n), .bus(i2c_link_if_i), .address_select_pin(pin),
    .sample_in(10'h2a5), .mode_active(mode), .conv_ready(cvr), .sample_strobe(ss),
    .reload_busy(rb));
  accel_link_asserts #(.POR_CYCLES(POR)) accel_link_asserts_i (
    .clock(clock), .reset_n(rst_t_n),
    .scl_m_o(i2c_link_if_i.scl_m_o), .scl_m_oe(i2c_link_if_i.scl_m_oe),
    .sda_m_o(i2c_link_if_i.sda_m_o), .sda_m_oe(i2c_link_if_i.sda_m_oe),
    .sda_t_o(i2c_link_if_i.sda_t_o), .sda_t_oe(i2c_link_if_i.sda_t_oe),
    .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda));
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One command through the master; read data only matters when acknowledged
  task automatic xfer(input logic rd, input logic sel, input logic [7:0] rg,
                      input logic [7:0] wd, input logic en, input logic [7:0] ed);
    @(negedge clock);
    cv = 1'b1;
    cr = rd;
    cs = sel;
    cg = rg;
    cw = wd;
    do @(posedge clock); while (ry !== 1'b1);
    @(negedge clock);
    cv = 1'b0;
    do @(posedge clock); while (rv !== 1'b1);
    chk("nack", 16'(en), 16'(rk));
    if (rd && !en) chk("rdata", 16'(ed), 16'(rdat));
  endtask
  // Skips one strobe first, since the interval across a rate change is not regular
  task automatic period(input int exp);
    int n;
    n = 0;
    @(posedge clock iff ss === 1'b1);
    do begin
      @(posedge clock);
      n++;
    end while (ss !== 1'b1 && n < 5000);
    chk("period", 16'(exp), 16'(n));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    wk <= (mode === 1'b1) ? wk + 1 : 0;
    if (rb === 1'b1) nrb <= nrb + 1;
    if (ss === 1'b1) begin
      num_checks++;
      if (wk < WAKE - 2) begin
        fail_count++;
        $display("BAD wake expected %0d seen %0d", WAKE, wk);
      end
    end
    if (cyc == 90000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    rst_t_n = 1'b1;
    xfer(1'b0, 1'b0, REG_MODE, 8'h80, 1'b0, 8'h00);
    chk("mode", 16'h1, 16'(mode));
    chk("conv", 16'h1, 16'(cvr));
    xfer(1'b0, 1'b1, REG_MODE, 8'h80, 1'b1, 8'h00);
    xfer(1'b1, 1'b0, REG_MODE, 8'h00, 1'b0, 8'h80);
    xfer(1'b1, 1'b0, REG_BW, 8'h00, 1'b0, BW_DEF);
    period(BASE);
    xfer(1'b1, 1'b0, REG_DATA_HI, 8'h00, 1'b0, 8'ha9);
    xfer(1'b0, 1'b0, REG_BW, 8'h05, 1'b0, 8'h00);
    period(BASE << 3);
    xfer(1'b0, 1'b0, REG_MODE, 8'h00, 1'b0, 8'h00);
    xfer(1'b0, 1'b0, REG_MODE, 8'h80, 1'b0, 8'h00);
    xfer(1'b0, 1'b0, REG_TRIM, 8'h55, 1'b0, 8'h00);
    xfer(1'b0, 1'b0, REG_NVM, 8'h08, 1'b0, 8'h00);
    chk("reload", 16'h1, 16'(nrb >= 36 && nrb <= 44));
    chk("mode", 16'h0, 16'(mode));
    xfer(1'b1, 1'b0, REG_TRIM, 8'h00, 1'b0, TRIM);
    xfer(1'b0, 1'b0, REG_MODE, 8'h80, 1'b0, 8'h00);
    @(negedge clock);
    pin = 1'b1;
    xfer(1'b0, 1'b0, REG_SRST, SRST_VAL, 1'b0, 8'h00);
    chk("mode", 16'h0, 16'(mode));
    chk("conv", 16'h0, 16'(cvr));
    @(negedge clock);
    fast = 1'b0;
    xfer(1'b1, 1'b0, REG_BW, 8'h00, 1'b0, BW_DEF);
    @(negedge clock);
    fast = 1'b1;
    rst_t_n = 1'b0;
    repeat (8) @(negedge clock);
    rst_t_n = 1'b1;
    xfer(1'b0, 1'b1, REG_MODE, 8'h80, 1'b1, 8'h00);
    repeat (POR) @(negedge clock);
    xfer(1'b1, 1'b1, REG_MODE, 8'h00, 1'b0, MODE_DEF);
    finish_test();
  end
endmodule
